// >>> dv/pwp_master.sv
`timescale 1ns/1ps
`default_nettype none
module pwp_master (
    // bus side
    input  wire logic                  core_clk,
    output var  pwp_pkg::pwp_bus_req_s bus_req,
    input  wire pwp_pkg::pwp_bus_rsp_s bus_rsp
);
    import pwp_pkg::*;
    initial bus_req = '0;
    // request held until pready is sampled, then released inverted
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        bus_req = '{1'b1, w, a, d, s};
        do begin
            @(posedge core_clk);
            n++;
        end while (bus_rsp.pready !== 1'b1 && n < 8);
        rd = bus_rsp.prdata;
        er = bus_rsp.pslverr;
        #1 bus_req = '{1'b0, ~w, ~a, ~d, ~s};
        // one idle edge so back-to-back calls never drive twice in a step
        @(posedge core_clk);
        #1;
    endtask
endmodule
`default_nettype wire

// >>> dv/pwp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwp_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module pwp_top_tb;
    import pwp_pkg::*;
    logic         core_clk = 0, rstn = 0, pw_req = 0, er;
    logic [4:0]   pw_idx = '0;
    logic [31:0]  rd, exp_v = '0;
    logic         pw_grant, pw_denied, clkctl_protected;
    pwp_bus_req_s bus_req;
    pwp_bus_rsp_s bus_rsp;
    int           error_cnt = 0, n_checks = 0, cyc = 0;
    always #4 core_clk = ~core_clk;
    pwp_top pwp_top_i (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .pw_req(pw_req), .pw_idx(pw_idx), .pw_grant(pw_grant),
        .pw_denied(pw_denied), .clkctl_protected(clkctl_protected));
    pwp_master pwp_master_i (.core_clk(core_clk), .bus_req(bus_req), .bus_rsp(bus_rsp));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // whole run needs about seventy cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            error_cnt++;
            stop_test();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic e);
        pwp_master_i.acc(1'b1, a, d, s, rd, er);
        `CHK(er, e)
    endtask
    // both views must read back the same masked vector
    task automatic rdv(input logic [3:0] s, input logic [31:0] m);
        pwp_master_i.acc(1'b0, `PWP_CLR_OFS, '0, s, rd, er);
        `CHK(rd, exp_v & m)
        pwp_master_i.acc(1'b0, `PWP_SET_OFS, '0, s, rd, er);
        `CHK(rd, exp_v & m)
    endtask
    task automatic gate(input logic [4:0] n);
        pw_req = 1;
        pw_idx = n;
        @(posedge core_clk);
        #1 pw_req = 0;
        `CHK({pw_denied, pw_grant}, {exp_v[n], ~exp_v[n]})
    endtask
    task automatic t_set();
        rdv(4'hF, '1);
        wr(`PWP_SET_OFS, 32'h0000_0108, 4'hF, 1'b0);
        exp_v = 32'h0000_0108;
        rdv(4'hF, '1);
        `CHK(clkctl_protected, 1'b1)
        wr(`PWP_SET_OFS, 32'h0000_0018, 4'hF, 1'b1);
        rdv(4'hF, '1);
        $display("test set done");
    endtask
    task automatic t_sparse();
        wr(`PWP_SET_OFS, 32'h0000_0200, 4'h2, 1'b0);
        exp_v[9] = 1'b1;
        rdv(4'h2, 32'h0000_FF00);
        wr(`PWP_SET_OFS, 32'h0001_0000, 4'hC, 1'b0);
        exp_v[16] = 1'b1;
        rdv(4'hC, 32'hFFFF_0000);
        $display("test sparse done");
    endtask
    task automatic t_clear();
        gate(5'h03);
        gate(5'h05);
        wr(`PWP_CLR_OFS, 32'h0000_0008, 4'hF, 1'b0);
        exp_v[`PWP_CLKCTL_BIT] = 1'b0;
        `CHK(clkctl_protected, 1'b0)
        gate(5'h03);
        wr(`PWP_CLR_OFS, 32'h0000_0008, 4'hF, 1'b1);
        wr(8'h10, 32'h0000_0200, 4'hF, 1'b1);
        rdv(4'hF, '1);
        $display("test clear done");
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        #1 rstn = 1;
        repeat (3) @(posedge core_clk);
        #1;
        t_set();
        t_sparse();
        t_clear();
        stop_test();
    end
endmodule
`default_nettype wire

// >>> hdl/pwp_map.svh
// What this block does
// - a one written to the clear view unprotects that peripheral
// - a one written to the set view protects that peripheral
// - both views read back the same protection vector, one means protected
// - writes to a protected peripheral are dropped and answered with an error
// - double protect or double unprotect of a peripheral answers with a bus error
// - zero bits written to either view change nothing
// - bit 3 of this group guards the generic clock controller
// - byte, halfword and word accesses each complete as one indivisible operation
// - each byte and halfword of a view is reached by strobes at the view's word address; other addresses answer with an error
// - address and data of a transfer are taken in one cycle
// - sparse byte, halfword and word transfers work for reads and writes
`ifndef PWP_MAP_SVH
`define PWP_MAP_SVH
`define PWP_CLR_OFS  8'h00
`define PWP_SET_OFS  8'h04
`define PWP_CLKCTL_BIT 3
`define PWP_IDX_W    5
`define PWP_PROT_RST 32'h0000_0000
`endif

// >>> hdl/pwp_pkg.sv
package pwp_pkg;
    typedef enum logic [1:0] {
        PWP_IDLE = 2'h1,
        PWP_RESP = 2'h2
    } pwp_state_e;

    typedef struct packed {
        logic        psel;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } pwp_bus_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pwp_bus_rsp_s;

    typedef struct packed {
        pwp_state_e   state;
        logic [31:0]  prot;
        pwp_bus_rsp_s rsp;
        logic         pw_grant;
        logic         pw_denied;
    } pwp_regs_s;
endpackage

// >>> hdl/pwp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwp_map.svh"
module pwp_top #(
    parameter logic [31:0] PROT_RESET = `PWP_PROT_RST
) (
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    // register bus
    input  wire pwp_pkg::pwp_bus_req_s    bus_req,
    output var  pwp_pkg::pwp_bus_rsp_s    bus_rsp,
    // peripheral write gate
    input  wire logic                     pw_req,
    input  wire logic [`PWP_IDX_W-1:0]    pw_idx,
    output var  logic                     pw_grant,
    output var  logic                     pw_denied,
    // status
    output var  logic                     clkctl_protected
);
    import pwp_pkg::*;

    logic        rst_meta_reg;
    logic        rst_sync_n_reg;
    pwp_regs_s   st_reg;
    pwp_regs_s   st_next;
    logic        req;
    logic        sel_clr;
    logic        sel_set;
    logic        err_map;
    logic        err_dbl;
    logic [31:0] wmask;

    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg   <= 1'b0;
            rst_sync_n_reg <= 1'b0;
        end else begin
            rst_meta_reg   <= 1'b1;
            rst_sync_n_reg <= rst_meta_reg;
        end
    end

    // byte lanes give sub-word access without read-modify-write
    assign req     = (st_reg.state == PWP_IDLE) && bus_req.psel;
    assign sel_clr = (bus_req.paddr == `PWP_CLR_OFS);
    assign sel_set = (bus_req.paddr == `PWP_SET_OFS);
    assign err_map = !(sel_clr || sel_set);
    assign wmask   = bus_req.pwdata & lane_mask(bus_req.pstrb);
    // whole write refused when any chosen bit already holds the asked state
    assign err_dbl = bus_req.pwrite &&
                     ((sel_set && |(wmask & st_reg.prot)) ||
                      (sel_clr && |(wmask & ~st_reg.prot)));

    always_comb begin
        st_next            = st_reg;
        st_next.rsp.pready = 1'b0;
        st_next.pw_grant   = 1'b0;
        st_next.pw_denied  = 1'b0;
        case (st_reg.state)
            PWP_IDLE: begin
                if (bus_req.psel) begin
                    st_next.state       = PWP_RESP;
                    st_next.rsp.pready  = 1'b1;
                    st_next.rsp.pslverr = err_map || err_dbl;
                    st_next.rsp.prdata  = '0;
                    if (!bus_req.pwrite && !err_map) begin
                        st_next.rsp.prdata = st_reg.prot & lane_mask(bus_req.pstrb);
                    end
                    if (bus_req.pwrite && !err_map && !err_dbl) begin
                        if (sel_set) begin
                            st_next.prot = st_reg.prot | wmask;
                        end else begin
                            st_next.prot = st_reg.prot & ~wmask;
                        end
                    end
                end
            end
            PWP_RESP: begin
                st_next.state = PWP_IDLE;
            end
            default: begin
                st_next.state = PWP_IDLE;
            end
        endcase
        // gate sees the vector before any write landing this cycle
        if (pw_req) begin
            if (st_reg.prot[pw_idx]) begin
                st_next.pw_denied = 1'b1;
            end else begin
                st_next.pw_grant = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_reg) begin
        if (!rst_sync_n_reg) begin
            st_reg <= '{state: PWP_IDLE, prot: PROT_RESET, rsp: '0,
                        pw_grant: 1'b0, pw_denied: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_rsp        = st_reg.rsp;
    assign pw_grant       = st_reg.pw_grant;
    assign pw_denied      = st_reg.pw_denied;
    assign clkctl_protected = st_reg.prot[`PWP_CLKCTL_BIT];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n_reg);

    a_clear_view_bits: assert property (
        req && bus_req.pwrite && sel_clr && !err_dbl |=>
        st_reg.prot == ($past(st_reg.prot) & ~$past(wmask)))
        else $error("clear view write did not clear selected bits");
    a_set_view_bits: assert property (
        req && bus_req.pwrite && sel_set && !err_dbl |=>
        st_reg.prot == ($past(st_reg.prot) | $past(wmask)))
        else $error("set view write did not set selected bits");
    a_views_read_same: assert property (
        req && !bus_req.pwrite && !err_map |=>
        bus_rsp.pready && !bus_rsp.pslverr &&
        bus_rsp.prdata == ($past(st_reg.prot) & lane_mask($past(bus_req.pstrb))))
        else $error("view read returned wrong vector");
    a_protected_write_drop: assert property (
        pw_req && st_reg.prot[pw_idx] |=> pw_denied && !pw_grant)
        else $error("write to protected peripheral not refused");
    a_double_op_err: assert property (
        req && err_dbl |=> bus_rsp.pslverr && st_reg.prot == $past(st_reg.prot))
        else $error("double protect or unprotect not reported");
    a_zero_bits_keep: assert property (
        req && bus_req.pwrite |=>
        ((st_reg.prot ^ $past(st_reg.prot)) & ~$past(wmask)) == '0)
        else $error("zero bit changed protection");
    a_clkctl_unprotect: assert property (
        req && bus_req.pwrite && sel_clr && !err_dbl && wmask[`PWP_CLKCTL_BIT] |=>
        !clkctl_protected)
        else $error("clock controller still protected after clear");
    a_single_answer: assert property (
        req |=> bus_rsp.pready ##1 !bus_rsp.pready)
        else $error("answer not a single pulse one cycle after request");
    a_unmapped_err: assert property (
        req && err_map |=> bus_rsp.pready && bus_rsp.pslverr)
        else $error("unmapped access not answered with error");

    // reset must silence every answer, whatever the bus does meanwhile
    a_reset_quiet: assert property (
        @(posedge core_clk) disable iff (1'b0)
        !rst_sync_n_reg |-> !bus_rsp.pready && !pw_grant && !pw_denied)
        else $error("answer seen while in reset");

    a_no_spurious_ready: assert property (
        !req |=>
        !bus_rsp.pready)
        else $error("ready without a taken request");

    a_answer_follows_take: assert property (
        bus_rsp.pready |->
        $past(req))
        else $error("ready not preceded by a take");

    a_ready_one_cycle: assert property (
        bus_rsp.pready |=>
        !bus_rsp.pready)
        else $error("ready held longer than one cycle");

    a_resp_ignores_psel: assert property (
        st_reg.state == PWP_RESP && bus_req.psel |=>
        !bus_rsp.pready)
        else $error("request taken during answer cycle");

    a_idle_after_resp: assert property (
        st_reg.state == PWP_RESP |=>
        st_reg.state == PWP_IDLE)
        else $error("state did not return to idle");

    a_state_onehot: assert property (
        $onehot(st_reg.state))
        else $error("state not one-hot");

    a_good_write_ok: assert property (
        req && bus_req.pwrite && !err_map && !err_dbl |=>
        bus_rsp.pready && !bus_rsp.pslverr)
        else $error("legal write answered with error");

    a_set_err_cond: assert property (
        req && bus_req.pwrite && sel_set && |(wmask & st_reg.prot) |=>
        bus_rsp.pslverr)
        else $error("double protect not reported");

    a_clr_err_cond: assert property (
        req && bus_req.pwrite && sel_clr && |(wmask & ~st_reg.prot) |=>
        bus_rsp.pslverr)
        else $error("double unprotect not reported");

    a_set_only_grows: assert property (
        req && bus_req.pwrite && sel_set |=>
        ($past(st_reg.prot) & ~st_reg.prot) == '0)
        else $error("set view write cleared a bit");

    a_clr_only_shrinks: assert property (
        req && bus_req.pwrite && sel_clr |=>
        (st_reg.prot & ~$past(st_reg.prot)) == '0)
        else $error("clear view write set a bit");

    a_clkctl_set: assert property (
        req && bus_req.pwrite && sel_set && !err_dbl && wmask[`PWP_CLKCTL_BIT] |=>
        clkctl_protected)
        else $error("clock controller not protected after set");

    a_clkctl_stable: assert property (
        !req |=>
        $stable(clkctl_protected))
        else $error("clock controller protection moved without a write");

    a_prot_quiet: assert property (
        !req |=>
        $stable(st_reg.prot))
        else $error("protection changed without a taken request");

    a_read_no_change: assert property (
        req && !bus_req.pwrite |=>
        $stable(st_reg.prot))
        else $error("read changed protection");

    a_error_no_change: assert property (
        req && err_map |=>
        $stable(st_reg.prot))
        else $error("unmapped access changed protection");

    a_write_data_zero: assert property (
        req && bus_req.pwrite |=>
        bus_rsp.prdata == '0)
        else $error("write answered with nonzero read data");

    a_unmapped_rdata: assert property (
        req && err_map |=>
        bus_rsp.prdata == '0)
        else $error("unmapped access returned data");

    a_answer_holds: assert property (
        !req |=>
        $stable(bus_rsp.pslverr) && $stable(bus_rsp.prdata))
        else $error("answer fields moved between answers");

    a_read_lanes_zero: assert property (
        req && !bus_req.pwrite && !err_map |=>
        (bus_rsp.prdata & ~lane_mask($past(bus_req.pstrb))) == '0)
        else $error("unstrobed read lane not zero");

    a_no_strobe_write: assert property (
        req && bus_req.pwrite && bus_req.pstrb == 4'h0 |=>
        $stable(st_reg.prot))
        else $error("write without strobes changed protection");

    // one check per byte lane, so a lane wired to the wrong strobe shows up
    generate
        for (genvar g = 0; g < 4; g++) begin : lane_chk
            a_lane_keep: assert property (
                req && bus_req.pwrite && !bus_req.pstrb[g] |=>
                st_reg.prot[g*8 +: 8] == $past(st_reg.prot[g*8 +: 8]))
                else $error("unstrobed byte lane changed protection");
        end
    endgenerate

    a_grant_free: assert property (
        pw_req && !st_reg.prot[pw_idx] |=>
        pw_grant && !pw_denied)
        else $error("write to free peripheral not granted");

    a_gate_old_vector: assert property (
        pw_req |=>
        pw_denied == $past(st_reg.prot[pw_idx]))
        else $error("gate did not use the vector of its own cycle");

    a_gate_exclusive: assert property (
        !(pw_grant && pw_denied))
        else $error("grant and denial at once");

    a_gate_idle: assert property (
        !pw_req |=>
        !pw_grant && !pw_denied)
        else $error("gate answered without an attempt");

    a_denied_follows_req: assert property (
        pw_denied |->
        $past(pw_req))
        else $error("denial without an attempt");

    a_grant_follows_req: assert property (
        pw_grant |->
        $past(pw_req))
        else $error("grant without an attempt");

    c_clear_write: cover property (req && bus_req.pwrite && sel_clr && !err_dbl);
    c_view_read:   cover property (req && !bus_req.pwrite && !err_map);
    c_set_write:   cover property (req && bus_req.pwrite && sel_set && !err_dbl);
    c_double_err:  cover property (req && err_dbl);
    c_denied:      cover property (pw_denied);
endmodule
`default_nettype wire
